// file: fsp_ctrl.sv
// fsp_ctrl: boot-loader side controller driving the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - page write refused unless the same page was erased beforehand
// - page write must use the page index of the preceding erase
// - page write refused until every buffer word has been loaded
// - erase: pattern x0000011 then store instruction within four cycles
// - load: pattern x0000001 then store instruction, data pair stored
// - a load to an already loaded word is refused
// - write: pattern x0000101 then store instruction within four cycles
// - page write pointer has all bits outside the page index cleared
// - busy flag cleared by re-enable after write before next section access
// - interrupts held off for the whole self-program operation
// - upper boot lock kept programmed unless boot update is allowed
// - lock set: pattern x0001001 then store, lock bits in low data
module fsp_ctrl #(
  parameter int PAGE_WORDS     = fsp_pkg::FSP_PAGE_WORDS,
  parameter int TIMEOUT_CYCLES = fsp_pkg::FSP_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  // device control register and store instruction
  output var  logic        dev_ctl_wr,
  output var  logic [7:0]  dev_ctl_wdata,
  input  wire logic [7:0]  dev_ctl_rdata,
  output var  logic        dev_store,
  output var  logic [15:0] dev_ptr,
  output var  logic [15:0] dev_pair,
  // device events
  input  wire logic        dev_ready_irq,
  input  wire logic        dev_eeprom_wr,
  // status
  output var  logic        busy,
  output var  logic        done,
  output var  logic        irq_block
);

  localparam int ADDR_W = fsp_pkg::FSP_ADDR_W;
  localparam int WORD_W = $clog2(PAGE_WORDS);
  localparam int PAGE_W = ADDR_W - WORD_W;
  localparam int TO_W   = $clog2(TIMEOUT_CYCLES + 1);

  // ==========================================================================
  // elaboration checks
  if (PAGE_WORDS < 2 || PAGE_WORDS > 1024 || (1 << WORD_W) != PAGE_WORDS) begin : g_bad_page
    $error("page size must be a power of two from 2 to 1024");
  end
  if (TIMEOUT_CYCLES < 4) begin : g_bad_tmo
    $error("timeout must be at least four cycles");
  end

  // ==========================================================================
  // state
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CTL  = 5'b00010,
    S_EXEC = 5'b00100,
    S_WAIT = 5'b01000,
    S_DONE = 5'b10000
  } fsp_state_t;

  typedef struct packed {
    fsp_state_t        st;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
    logic [5:0]        lock;
    logic              irq_en;
    logic              allow_boot;
    logic [2:0]        op;
    logic              reen_pend;
    logic [PAGE_W-1:0] er_page;
    logic              er_valid;
    logic              busy;
    logic              done;
    logic [3:0]        err;
    logic [TO_W-1:0]   tmo;
    logic              ctl_wr;
    logic [7:0]        ctl_wdata;
    logic              store;
    logic [15:0]       ptr;
    logic [15:0]       pair;
    logic [15:0]       rdata;
  } fsp_ctl_t;

  fsp_ctl_t          r_reg;
  fsp_ctl_t          r_next;
  logic              win_open;
  logic              win_missed;
  logic              bm_hit;
  logic              bm_full;
  logic              bm_empty;
  logic              bm_set;
  logic              bm_clr;
  logic [WORD_W-1:0] bm_idx;
  logic              fin_ok;

  // ==========================================================================
  // helpers
  fsp_window u_window (
    .core_clk (core_clk),
    .rst      (rst),
    .arm      (r_reg.ctl_wr),
    .fire     (r_reg.store),
    .win_open (win_open),
    .missed   (win_missed)
  );

  fsp_bitmap #(
    .ENTRIES (PAGE_WORDS),
    .IDX_W   (WORD_W)
  ) u_bitmap (
    .core_clk (core_clk),
    .rst      (rst),
    .set      (bm_set),
    .clr      (bm_clr),
    .idx      (bm_idx),
    .hit      (bm_hit),
    .full     (bm_full),
    .empty    (bm_empty)
  );

  // completion seen either as store enable clear or the ready interrupt
  assign fin_ok = r_reg.st == S_WAIT && r_reg.tmo != '0 &&
                  (!dev_ctl_rdata[fsp_pkg::FSP_BIT_STORE] || (r_reg.irq_en && dev_ready_irq));
  assign bm_idx = (r_reg.st == S_IDLE) ? r_reg.addr[WORD_W-1:0] : r_reg.ptr[WORD_W:1];
  assign bm_set = fin_ok && r_reg.op == fsp_pkg::FSP_CMD_LOAD;
  // the device drops the buffer on these events, so the record follows it
  assign bm_clr = (fin_ok && (r_reg.op == fsp_pkg::FSP_CMD_WRITE || r_reg.op == fsp_pkg::FSP_CMD_REEN)) ||
                  (dev_eeprom_wr && !bm_empty);

  // ==========================================================================
  // next state
  always_comb begin
    logic [3:0] err_set;
    logic [3:0] err_clr;
    logic [7:0] pat;
    err_set = 4'h0;
    err_clr = 4'h0;
    pat     = 8'h00;
    r_next  = r_reg;
    r_next.rdata  = 16'h0000;
    r_next.ctl_wr = 1'b0;
    r_next.store  = 1'b0;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        fsp_pkg::FSP_REG_ADDR:   r_next.addr = reg_wdata[ADDR_W-1:0];
        fsp_pkg::FSP_REG_DATA:   r_next.data = reg_wdata;
        fsp_pkg::FSP_REG_LOCK:   r_next.lock = reg_wdata[5:0];
        fsp_pkg::FSP_REG_CTRL: begin
          r_next.irq_en     = reg_wdata[0];
          r_next.allow_boot = reg_wdata[1];
        end
        fsp_pkg::FSP_REG_STATUS: err_clr = reg_wdata[5:2];
        default: ;
      endcase
    end

    // register reads, data in the following cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        fsp_pkg::FSP_REG_ADDR:   r_next.rdata = {1'b0, r_reg.addr};
        fsp_pkg::FSP_REG_DATA:   r_next.rdata = r_reg.data;
        fsp_pkg::FSP_REG_LOCK:   r_next.rdata = {10'h000, r_reg.lock};
        fsp_pkg::FSP_REG_CTRL:   r_next.rdata = {14'h0000, r_reg.allow_boot, r_reg.irq_en};
        fsp_pkg::FSP_REG_STATUS: r_next.rdata = {dev_ctl_rdata, 1'b0, bm_full, r_reg.err, r_reg.done, r_reg.busy};
        default:                 r_next.rdata = 16'h0000;
      endcase
    end

    unique case (r_reg.st)
      S_IDLE: begin
        if (reg_wr && reg_addr == fsp_pkg::FSP_REG_CMD) begin
          r_next.op        = reg_wdata[2:0];
          r_next.reen_pend = 1'b0;
          r_next.ptr       = {r_reg.addr, 1'b0};
          r_next.pair      = r_reg.data;
          r_next.st        = S_CTL;
          unique case (reg_wdata[2:0])
            fsp_pkg::FSP_CMD_LOAD: begin
              if (bm_hit) begin
                err_set[fsp_pkg::FSP_ERR_DUP] = 1'b1;
                r_next.st = S_IDLE;
              end
            end
            fsp_pkg::FSP_CMD_ERASE: ;
            fsp_pkg::FSP_CMD_WRITE: begin
              r_next.ptr = {r_reg.addr[ADDR_W-1:WORD_W], {(WORD_W+1){1'b0}}};
              if (!r_reg.er_valid || r_reg.er_page != r_reg.addr[ADDR_W-1:WORD_W]) begin
                err_set[fsp_pkg::FSP_ERR_ORDER] = 1'b1;
                r_next.st = S_IDLE;
              end else if (!bm_full) begin
                err_set[fsp_pkg::FSP_ERR_PART] = 1'b1;
                r_next.st = S_IDLE;
              end
            end
            fsp_pkg::FSP_CMD_LOCK: begin
              r_next.ptr  = 16'h0001;
              r_next.pair = {8'h00, fsp_pkg::FSP_LOCK_KEEP, r_reg.lock};
              if (!r_reg.allow_boot) begin
                r_next.pair[fsp_pkg::FSP_LOCK_UPPER] = 1'b0;
              end
            end
            fsp_pkg::FSP_CMD_REEN: ;
            default: r_next.st = S_IDLE;
          endcase
          if (r_next.st == S_CTL) begin
            r_next.busy = 1'b1;
            r_next.done = 1'b0;
          end
        end
      end
      S_CTL: begin
        unique case (r_reg.op)
          fsp_pkg::FSP_CMD_LOAD:  pat = fsp_pkg::FSP_PAT_LOAD;
          fsp_pkg::FSP_CMD_ERASE: pat = fsp_pkg::FSP_PAT_ERASE;
          fsp_pkg::FSP_CMD_WRITE: pat = fsp_pkg::FSP_PAT_WRITE;
          fsp_pkg::FSP_CMD_LOCK:  pat = fsp_pkg::FSP_PAT_LOCK;
          default:                pat = fsp_pkg::FSP_PAT_REEN;
        endcase
        r_next.ctl_wdata = pat | (r_reg.irq_en ? fsp_pkg::FSP_PAT_IRQ_EN : 8'h00);
        r_next.ctl_wr    = 1'b1;
        r_next.st        = S_EXEC;
      end
      S_EXEC: begin
        // store goes out the cycle after the control write, first cycle of the window
        r_next.store = 1'b1;
        r_next.tmo   = '0;
        r_next.st    = S_WAIT;
      end
      S_WAIT: begin
        r_next.tmo = r_reg.tmo + TO_W'(1);
        if (fin_ok) begin
          r_next.st = S_DONE;
          if (r_reg.op == fsp_pkg::FSP_CMD_ERASE) begin
            r_next.er_page  = r_reg.ptr[ADDR_W:WORD_W+1];
            r_next.er_valid = 1'b1;
          end
          if (r_reg.op == fsp_pkg::FSP_CMD_WRITE) begin
            r_next.er_valid = 1'b0;
            // busy flag set means the section stays blocked until re-enabled
            if (dev_ctl_rdata[fsp_pkg::FSP_BIT_BUSY]) begin
              r_next.op        = fsp_pkg::FSP_CMD_REEN;
              r_next.reen_pend = 1'b1;
              r_next.st        = S_CTL;
            end
          end
        end else if (r_reg.tmo == TO_W'(TIMEOUT_CYCLES - 1)) begin
          err_set[fsp_pkg::FSP_ERR_TMO] = 1'b1;
          r_next.st = S_DONE;
        end
      end
      S_DONE: begin
        r_next.busy      = 1'b0;
        r_next.done      = 1'b1;
        r_next.reen_pend = 1'b0;
        r_next.st        = S_IDLE;
      end
    endcase

    if (win_missed) begin
      err_set[fsp_pkg::FSP_ERR_TMO] = 1'b1;
    end
    // a hardware set beats a software clear in the same cycle
    r_next.err = (r_reg.err & ~err_clr) | err_set;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg    <= '0;
      r_reg.st <= S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata     = r_reg.rdata;
  assign dev_ctl_wr    = r_reg.ctl_wr;
  assign dev_ctl_wdata = r_reg.ctl_wdata;
  assign dev_store     = r_reg.store;
  assign dev_ptr       = r_reg.ptr;
  assign dev_pair      = r_reg.pair;
  assign busy          = r_reg.busy;
  assign done          = r_reg.done;
  // interrupts stay off while any operation is under way
  assign irq_block     = r_reg.busy;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_reen_issue;
    dev_ctl_wr && dev_ctl_wdata[4:0] == fsp_pkg::FSP_PAT_REEN[4:0] ##1 dev_store;
  endsequence

  sequence s_write_busy_done;
    fin_ok && r_reg.op == fsp_pkg::FSP_CMD_WRITE && dev_ctl_rdata[fsp_pkg::FSP_BIT_BUSY];
  endsequence

  a_store_in_window: assert property (dev_store |-> win_open && $past(dev_ctl_wr))
    else $error("store issued outside the arming window");
  a_ctl_then_store: assert property (dev_ctl_wr |=> dev_store ##1 !dev_store)
    else $error("control write not followed by one store");
  a_valid_pattern: assert property (dev_ctl_wr |-> dev_ctl_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11})
    else $error("invalid control pattern");
  a_write_ptr_clean: assert property (dev_ctl_wr && dev_ctl_wdata[4:0] == fsp_pkg::FSP_PAT_WRITE[4:0]
                                      |-> dev_ptr[WORD_W:0] == '0)
    else $error("page write pointer has word bits set");
  a_write_same_page: assert property (dev_ctl_wr && dev_ctl_wdata[4:0] == fsp_pkg::FSP_PAT_WRITE[4:0]
                                      |-> r_reg.er_valid && dev_ptr[ADDR_W:WORD_W+1] == r_reg.er_page)
    else $error("page write to a page not erased");
  a_write_full_buf: assert property (dev_ctl_wr && dev_ctl_wdata[4:0] == fsp_pkg::FSP_PAT_WRITE[4:0]
                                     |-> bm_full)
    else $error("page write with buffer not fully loaded");
  a_load_no_dup: assert property (dev_ctl_wr && dev_ctl_wdata[4:0] == fsp_pkg::FSP_PAT_LOAD[4:0] |-> !bm_hit)
    else $error("buffer word loaded twice");
  a_lock_upper_kept: assert property (dev_ctl_wr && dev_ctl_wdata[4:0] == fsp_pkg::FSP_PAT_LOCK[4:0] && !r_reg.allow_boot
                                      |-> !dev_pair[fsp_pkg::FSP_LOCK_UPPER] && dev_pair[7:6] == 2'h3)
    else $error("upper boot lock left unprogrammed");
  a_reen_after_write: assert property (s_write_busy_done |-> ##2 s_reen_issue)
    else $error("no re-enable after page write");
  a_irq_held: assert property (dev_ctl_wr |-> irq_block ##1 (irq_block && dev_store))
    else $error("interrupts not held during operation");
  a_eeprom_discard: assert property (dev_eeprom_wr && !bm_empty |=> bm_empty)
    else $error("buffer record kept after eeprom write");

endmodule // fsp_ctrl
`default_nettype wire

// file: fsp_pkg.sv
// fsp_pkg: constants shared by the flash self-program controller
package fsp_pkg;

  // ==========================================================================
  // clock and timing
  localparam int          FSP_CLK_MHZ     = 40;
  // completion timeout; no figure is given for it, so this is a generous margin
  localparam int          FSP_TIMEOUT_US  = 10000;
  localparam int          FSP_TIMEOUT_CYC = FSP_TIMEOUT_US * FSP_CLK_MHZ;
  // store-program instruction must follow the control write within this many cycles
  localparam logic [2:0]  FSP_WINDOW_CYC  = 3'h4;

  // ==========================================================================
  // flash geometry
  localparam int          FSP_PAGE_WORDS  = 64;
  localparam int          FSP_ADDR_W      = 15;

  // ==========================================================================
  // device control register patterns and bits
  localparam logic [7:0]  FSP_PAT_LOAD    = 8'h01;
  localparam logic [7:0]  FSP_PAT_ERASE   = 8'h03;
  localparam logic [7:0]  FSP_PAT_WRITE   = 8'h05;
  localparam logic [7:0]  FSP_PAT_LOCK    = 8'h09;
  localparam logic [7:0]  FSP_PAT_REEN    = 8'h11;
  localparam logic [7:0]  FSP_PAT_IRQ_EN  = 8'h80;
  localparam int          FSP_BIT_STORE   = 0;
  localparam int          FSP_BIT_BUSY    = 6;
  localparam int          FSP_LOCK_UPPER  = 4;
  localparam logic [1:0]  FSP_LOCK_KEEP   = 2'h3;

  // ==========================================================================
  // controller commands
  localparam logic [2:0]  FSP_CMD_LOAD    = 3'h1;
  localparam logic [2:0]  FSP_CMD_ERASE   = 3'h2;
  localparam logic [2:0]  FSP_CMD_WRITE   = 3'h3;
  localparam logic [2:0]  FSP_CMD_LOCK    = 3'h4;
  localparam logic [2:0]  FSP_CMD_REEN    = 3'h5;

  // ==========================================================================
  // controller register map
  localparam logic [3:0]  FSP_REG_CMD     = 4'h0;
  localparam logic [3:0]  FSP_REG_ADDR    = 4'h1;
  localparam logic [3:0]  FSP_REG_DATA    = 4'h2;
  localparam logic [3:0]  FSP_REG_LOCK    = 4'h3;
  localparam logic [3:0]  FSP_REG_CTRL    = 4'h4;
  localparam logic [3:0]  FSP_REG_STATUS  = 4'h5;
  localparam int          FSP_ERR_ORDER   = 0;
  localparam int          FSP_ERR_DUP     = 1;
  localparam int          FSP_ERR_PART    = 2;
  localparam int          FSP_ERR_TMO     = 3;

endpackage

// file: fsp_window.sv
// fsp_window: three-cycle arming window after a control register write
`timescale 1ns/1ps
`default_nettype none
module fsp_window (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // window control
  input  wire logic arm,
  input  wire logic fire,
  // window state
  output var  logic win_open,
  output var  logic missed
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       open;
    logic       missed;
  } fsp_win_t;

  fsp_win_t r_reg;
  fsp_win_t r_next;

  // ==========================================================================
  // counter
  always_comb begin
    r_next        = r_reg;
    r_next.missed = 1'b0;
    if (arm) begin
      // a fresh control write restarts the count
      r_next.cnt  = 3'h1;
      r_next.open = 1'b1;
    end else if (r_reg.open) begin
      r_next.cnt = r_reg.cnt + 3'h1;
      if (fire) begin
        r_next.open = 1'b0;
      end else if (r_reg.cnt == fsp_pkg::FSP_WINDOW_CYC - 3'h1) begin
        r_next.open   = 1'b0;
        r_next.missed = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign win_open = r_reg.open;
  assign missed   = r_reg.missed;

endmodule // fsp_window
`default_nettype wire

// file: fsp_bitmap.sv
// fsp_bitmap: record of loaded page buffer locations
`timescale 1ns/1ps
`default_nettype none
module fsp_bitmap #(
  parameter int ENTRIES = 64,
  parameter int IDX_W   = $clog2(ENTRIES)
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // updates
  input  wire logic             set,
  input  wire logic             clr,
  input  wire logic [IDX_W-1:0] idx,
  // state
  output var  logic             hit,
  output var  logic             full,
  output var  logic             empty
);

  typedef struct packed {
    logic [ENTRIES-1:0] map;
  } fsp_bm_t;

  fsp_bm_t            r_reg;
  fsp_bm_t            r_next;
  logic [ENTRIES-1:0] bits_next;

  // ==========================================================================
  // elaboration checks
  if (ENTRIES < 2 || IDX_W != $clog2(ENTRIES)) begin : g_bad_cfg
    $error("index width must match the entry count");
  end

  // ==========================================================================
  // per-entry update; a clear beats a set because cleared data is lost anyway
  for (genvar i = 0; i < ENTRIES; i++) begin : g_bit
    assign bits_next[i] = !clr && (r_reg.map[i] || (set && idx == IDX_W'(i)));
  end

  always_comb begin
    r_next     = r_reg;
    r_next.map = bits_next;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hit   = r_reg.map[idx];
  assign full  = &r_reg.map;
  assign empty = ~|r_reg.map;

endmodule // fsp_bitmap
`default_nettype wire

// file: fsp_dev_model.sv
// fsp_dev_model: behavioural flash self-program device seen by the controller
`timescale 1ns/1ps
`default_nettype none
module fsp_dev_model #(
  parameter int PAGE_WORDS = 8,
  parameter int OP_CYC     = 20
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // control register and store instruction
  input  wire logic        dev_ctl_wr,
  input  wire logic [7:0]  dev_ctl_wdata,
  output var  logic [7:0]  dev_ctl_rdata,
  input  wire logic        dev_store,
  input  wire logic [15:0] dev_ptr,
  input  wire logic [15:0] dev_pair,
  // events and fault injection
  output var  logic        dev_ready_irq,
  input  wire logic        dev_eeprom_wr,
  input  wire logic        hang
);
  localparam int WB = $clog2(PAGE_WORDS);
  logic [7:0]            ctl;
  logic                  sect_busy;
  logic [2:0]            win;
  int                    cnt;
  logic [PAGE_WORDS-1:0] loaded;
  logic [15:0]           mem [PAGE_WORDS];
  logic [15:0]           last_page;
  logic [5:0]            lock;
  // ==========================================================================
  // readback and ready request
  assign dev_ctl_rdata = {ctl[7], sect_busy, 1'b0, ctl[4:0]};
  assign dev_ready_irq = ctl[7] & ~ctl[0];
  // ==========================================================================
  // command window and operations; every target is treated as the busy section
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl <= 8'h00;
      sect_busy <= 1'b0;
      win <= 3'h0;
      cnt <= 0;
      loaded <= '0;
      lock <= 6'h3f;
      last_page <= 16'h0000;
    end else begin
      if (dev_eeprom_wr) loaded <= '0;
      if (dev_ctl_wr && cnt == 0 && dev_ctl_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) begin
        ctl <= dev_ctl_wdata & 8'h9f;
        win <= 3'h4;
      end else if (cnt != 0) begin
        if (!hang) cnt <= cnt - 1;
        if (!hang && cnt == 1) ctl[4:0] <= 5'h00;
        if (!hang && cnt == 1 && ctl[2]) loaded <= '0;
      end else if (dev_store && win != 3'h0) begin
        win <= 3'h0;
        ctl[4:0] <= 5'h00;
        case (ctl[4:0])
          5'h01: begin
            mem[dev_ptr[WB:1]] <= dev_pair;
            loaded[dev_ptr[WB:1]] <= 1'b1;
            sect_busy <= 1'b0;
          end
          5'h03, 5'h05: begin
            ctl[4:0] <= ctl[4:0];
            cnt <= OP_CYC;
            sect_busy <= 1'b1;
            last_page <= dev_ptr >> (WB + 1);
          end
          5'h09: lock <= dev_pair[5:0];
          default: begin
            sect_busy <= 1'b0;
            loaded <= '0;
          end
        endcase
      end else if (win != 3'h0) begin
        win <= win - 3'h1;
        if (win == 3'h1) ctl[4:0] <= 5'h00;
      end
    end
  end
endmodule // fsp_dev_model
`default_nettype wire

// file: fsp_ctrl_test.sv
// fsp_ctrl_test: self-checking bench for the flash self-program controller
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_test;
  localparam int PW  = 8;
  localparam int TMO = 64;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        dev_eeprom_wr = 1'b0;
  logic        hang = 1'b0;
  logic [15:0] reg_rdata, dev_ptr, dev_pair, s;
  logic [7:0]  dev_ctl_wdata, dev_ctl_rdata;
  logic        dev_ctl_wr, dev_store, dev_ready_irq, busy, done, irq_block;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  fsp_ctrl #(.PAGE_WORDS(PW), .TIMEOUT_CYCLES(TMO)) fsp_ctrl_inst (.core_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .dev_ctl_wr, .dev_ctl_wdata, .dev_ctl_rdata, .dev_store, .dev_ptr,
    .dev_pair, .dev_ready_irq, .dev_eeprom_wr, .busy, .done, .irq_block);
  fsp_dev_model #(.PAGE_WORDS(PW)) fsp_dev_model_inst (.core_clk, .rst, .dev_ctl_wr, .dev_ctl_wdata,
    .dev_ctl_rdata, .dev_store, .dev_ptr, .dev_pair, .dev_ready_irq, .dev_eeprom_wr, .hang);
  // ==========================================================================
  // clock, hang guard, closing report
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // register port access
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 s = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded poll: a stuck busy ends the loop and shows up in the status compare
  task automatic idle();
    for (int i = 0; i < 400; i++) begin
      rd(fsp_pkg::FSP_REG_STATUS);
      if (s[0] === 1'b0) break;
    end
  endtask
  task automatic op(input logic [15:0] a, input logic [2:0] c, input logic [15:0] m, input logic [15:0] e);
    wr(fsp_pkg::FSP_REG_ADDR, a);
    wr(fsp_pkg::FSP_REG_CMD, {13'h0000, c});
    idle();
    chk("status", e, s & m);
  endtask
  // ==========================================================================
  // tests
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'hf);
    chk("unmapped", 16'h0000, s);
    rd(fsp_pkg::FSP_REG_STATUS);
    chk("reset status", 16'h0000, s);
    $display("test reset done");
    // fill page 1 backwards, then compare every buffer word
    for (int i = PW - 1; i >= 0; i--) begin
      wr(fsp_pkg::FSP_REG_DATA, 16'ha500 + 16'(i));
      op(16'(PW + i), fsp_pkg::FSP_CMD_LOAD, 16'hffff, (i == 0) ? 16'h0042 : 16'h0002);
    end
    for (int i = 0; i < PW; i++) chk("buffer word", 16'ha500 + 16'(i), fsp_dev_model_inst.mem[i]);
    $display("test load done");
    op(16'(PW + 3), fsp_pkg::FSP_CMD_LOAD, 16'h003d, 16'h0008);
    wr(fsp_pkg::FSP_REG_STATUS, 16'h003c);
    op(16'(PW), fsp_pkg::FSP_CMD_WRITE, 16'h003d, 16'h0004);
    wr(fsp_pkg::FSP_REG_STATUS, 16'h003c);
    op(16'(PW + 5), fsp_pkg::FSP_CMD_ERASE, 16'hffff, 16'h4042);
    chk("erased page", 16'h0001, fsp_dev_model_inst.last_page);
    op(16'(2 * PW), fsp_pkg::FSP_CMD_WRITE, 16'h003d, 16'h0004);
    wr(fsp_pkg::FSP_REG_STATUS, 16'h003c);
    $display("test refusals done");
    wr(fsp_pkg::FSP_REG_ADDR, 16'(PW + 5));
    wr(fsp_pkg::FSP_REG_CMD, 16'(fsp_pkg::FSP_CMD_WRITE));
    #1 chk("irq block", 16'h0001, {15'h0000, irq_block});
    idle();
    chk("status", 16'h0002, s);
    chk("write pointer", 16'(2 * PW), dev_ptr);
    chk("busy done pins", 16'h0001, {14'h0000, busy, done});
    chk("buffer record", 16'h0000, 16'(fsp_dev_model_inst.loaded));
    $display("test page write done");
    wr(fsp_pkg::FSP_REG_DATA, 16'h1234);
    op(16'(PW), fsp_pkg::FSP_CMD_LOAD, 16'hffff, 16'h0002);
    op(16'(PW), fsp_pkg::FSP_CMD_ERASE, 16'hffff, 16'h4002);
    op(16'(PW), fsp_pkg::FSP_CMD_WRITE, 16'h003d, 16'h0010);
    wr(fsp_pkg::FSP_REG_STATUS, 16'h003c);
    @(posedge core_clk);
    dev_eeprom_wr <= 1'b1;
    @(posedge core_clk);
    dev_eeprom_wr <= 1'b0;
    @(posedge core_clk);
    chk("buffer after eeprom", 16'h0000, 16'(fsp_dev_model_inst.loaded));
    op(16'(PW + 1), fsp_pkg::FSP_CMD_LOAD, 16'h003d, 16'h0000);
    $display("test partial page done");
    wr(fsp_pkg::FSP_REG_LOCK, 16'h003f);
    op(16'h0000, fsp_pkg::FSP_CMD_LOCK, 16'h00ff, 16'h0002);
    chk("lock pair", 16'h00ef, dev_pair);
    chk("lock pointer", 16'h0001, dev_ptr);
    chk("lock bits", 16'h002f, {10'h000, fsp_dev_model_inst.lock});
    $display("test lock done");
    wr(fsp_pkg::FSP_REG_CTRL, 16'h0001);
    op(16'h0000, fsp_pkg::FSP_CMD_LOAD, 16'hffff, 16'h8002);
    chk("pattern", 16'h0081, {8'h00, dev_ctl_wdata});
    chk("ready request", 16'h0001, {15'h0000, dev_ready_irq});
    wr(fsp_pkg::FSP_REG_CTRL, 16'h0000);
    $display("test ready request done");
    hang <= 1'b1;
    op(16'h0000, fsp_pkg::FSP_CMD_ERASE, 16'h0021, 16'h0020);
    hang <= 1'b0;
    repeat (30) @(posedge core_clk);
    wr(fsp_pkg::FSP_REG_STATUS, 16'h003c);
    rd(fsp_pkg::FSP_REG_STATUS);
    chk("errors cleared", 16'h0000, s & 16'h003d);
    $display("test timeout done");
    conclude();
  end
endmodule // fsp_ctrl_test
`default_nettype wire
